/* File: src/okg_pkg.sv */
package okg_pkg;

  // ----------------------------------------------------------------
  // Character codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_BEL   = 8'h07;
  localparam logic [7:0] CH_BS    = 8'h08;
  localparam logic [7:0] CH_TAB   = 8'h09;
  localparam logic [7:0] CH_LF    = 8'h0a;
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_ESC   = 8'h1b;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_QMARK = 8'h3f;
  localparam logic [7:0] CH_LOW_A = 8'h61;
  localparam logic [7:0] CH_LOW_Z = 8'h7a;
  localparam logic [7:0] CASE_GAP = 8'h20;
  localparam logic [7:0] CTRL_MASK = 8'h1f;

  // ----------------------------------------------------------------
  // Escape final characters
  // ----------------------------------------------------------------
  localparam logic [7:0] EF_ALT_ON  = 8'h3d;
  localparam logic [7:0] EF_ALT_OFF = 8'h3e;
  localparam logic [7:0] EF_UP      = 8'h41;
  localparam logic [7:0] EF_DOWN    = 8'h42;
  localparam logic [7:0] EF_RIGHT   = 8'h43;
  localparam logic [7:0] EF_LEFT    = 8'h44;
  localparam logic [7:0] EF_MAINT_X = 8'h45;
  localparam logic [7:0] EF_HOME    = 8'h48;
  localparam logic [7:0] EF_RLF     = 8'h49;
  localparam logic [7:0] EF_SCREEN_TAIL = 8'h4a;
  localparam logic [7:0] EF_LINE_TAIL   = 8'h4b;
  localparam logic [7:0] EF_MAINT   = 8'h4d;
  localparam logic [7:0] EF_TEST    = 8'h50;
  localparam logic [7:0] EF_RASTER  = 8'h51;
  localparam logic [7:0] EF_RESET   = 8'h52;
  localparam logic [7:0] EF_PRINT   = 8'h5d;
  localparam logic [7:0] ALT_DIGIT  = 8'h70;
  localparam logic [7:0] ALT_POINT  = 8'h6e;
  localparam logic [7:0] ALT_ENTER  = 8'h4d;

  // ----------------------------------------------------------------
  // Key identifiers
  // ----------------------------------------------------------------
  localparam logic [6:0] KEY_COPY  = 7'h00;
  localparam logic [6:0] KP_NINE   = 7'h09;
  localparam logic [6:0] KP_POINT  = 7'h0a;
  localparam logic [6:0] KP_ENTER  = 7'h0b;
  localparam logic [6:0] KP_UP     = 7'h0c;
  localparam logic [6:0] KP_DOWN   = 7'h0d;
  localparam logic [6:0] KP_RIGHT  = 7'h0e;
  localparam logic [6:0] KP_LEFT   = 7'h0f;
  localparam logic [6:0] KP_TEST   = 7'h10;
  localparam logic [6:0] KP_BACK   = 7'h11;
  localparam logic [6:0] KP_FWD    = 7'h12;
  localparam logic [6:0] KP_BLANK0 = 7'h13;
  localparam logic [6:0] KP_BLANK1 = 7'h14;
  localparam logic [6:0] KP_BLANK2 = 7'h15;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam int         CTRL_ALT    = 0;
  localparam int         ST_ALT      = 0;
  localparam int         ST_MAINT    = 1;
  localparam int         ST_BUSY     = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 125;
  localparam int REPEAT_PERIOD_MS = 100;
  localparam int REPEAT_CYCLES    = REPEAT_PERIOD_MS * CLK_MHZ * 1000;

  typedef enum logic [1:0] {IP_IDLE, IP_ESC, IP_ESCQ} okg_ip_t;

  typedef enum logic [4:0] {
    ACT_NONE, ACT_WRITE, ACT_BELL, ACT_CR, ACT_LF, ACT_BS, ACT_TAB,
    ACT_UP, ACT_DOWN, ACT_RIGHT, ACT_LEFT, ACT_HOME, ACT_RLF,
    ACT_SCREEN_TAIL, ACT_LINE_TAIL, ACT_SELFTEST, ACT_RASTER, ACT_RESET,
    ACT_PRINT
  } okg_act_t;

  typedef struct packed {
    logic [1:0]      len;
    logic [2:0][7:0] seq;
  } okg_enc_t;

endpackage : okg_pkg

/* File: src/okg_top.sv */
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module okg_top
  import okg_pkg::*;
#(
  parameter int unsigned REPEAT_LEN = REPEAT_CYCLES
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        key_valid,
  output logic             key_ready,
  input  wire logic        key_keypad,
  input  wire logic [6:0]  key_id,
  input  wire logic        key_held,
  input  wire logic        shift_key,
  input  wire logic        uppercase_lock_key,
  input  wire logic        control_modifier_key,
  input  wire logic        repeat_key,
  input  wire logic        printer_present,
  output logic             code_valid,
  output logic [7:0]       code,
  input  wire logic        code_ready,
  output logic             act_valid,
  output okg_act_t         act,
  output logic [7:0]       act_char,
  output logic             alt_keypad,
  output logic             maint_mode
);

  localparam logic [23:0] RPT_LAST = 24'(REPEAT_LEN - 1);

  typedef struct packed {
    logic [1:0]      len;
    logic [2:0][7:0] seq;
    logic            last_kp;
    logic [6:0]      last_id;
    logic            last_rep;
    logic [23:0]     rpt;
    okg_ip_t         ip;
    logic            alt;
    logic            maint;
    logic            act_valid;
    okg_act_t        act;
    logic [7:0]      act_char;
    logic            aw_held;
    logic [3:0]      awaddr;
    logic            w_held;
    logic [31:0]     wdata;
    logic [3:0]      wstrb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
  } okg_state_t;

  okg_state_t s;
  okg_state_t next_s;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic addr_ok(input logic [3:0] a);
    addr_ok = (a == ADDR_CTRL) || (a == ADDR_STATUS);
  endfunction : addr_ok

  function automatic logic [7:0] shift_sym(input logic [7:0] c);
    case (c)
      8'h31: shift_sym = 8'h21;
      8'h32: shift_sym = 8'h40;
      8'h33: shift_sym = 8'h23;
      8'h34: shift_sym = 8'h24;
      8'h35: shift_sym = 8'h25;
      8'h36: shift_sym = 8'h5e;
      8'h37: shift_sym = 8'h26;
      8'h38: shift_sym = 8'h2a;
      8'h39: shift_sym = 8'h28;
      8'h30: shift_sym = 8'h29;
      8'h2d: shift_sym = 8'h5f;
      8'h3d: shift_sym = 8'h2b;
      8'h5b: shift_sym = 8'h7b;
      8'h5d: shift_sym = 8'h7d;
      8'h3b: shift_sym = 8'h3a;
      8'h27: shift_sym = 8'h22;
      8'h2c: shift_sym = 8'h3c;
      8'h2e: shift_sym = 8'h3e;
      8'h2f: shift_sym = 8'h3f;
      8'h60: shift_sym = 8'h7e;
      8'h5c: shift_sym = 8'h7c;
      default: shift_sym = c;
    endcase
  endfunction : shift_sym

  function automatic okg_enc_t esc2(input logic [7:0] f);
    okg_enc_t e;
    e.len    = 2'd2;
    e.seq    = '0;
    e.seq[0] = CH_ESC;
    e.seq[1] = f;
    return e;
  endfunction : esc2

  // Keypad keys ignore every modifier, so only the mode reaches them
  function automatic okg_enc_t encode(input logic kp, input logic [6:0] id,
                                      input logic sh, input logic lk,
                                      input logic ct, input logic al);
    okg_enc_t   e;
    logic [7:0] c;
    e.len = 2'd1;
    e.seq = '0;
    c     = {1'b0, id};
    if (kp)
    begin
      if (id <= KP_NINE)
      begin
        if (al)
        begin
          e.len    = 2'd3;
          e.seq[0] = CH_ESC;
          e.seq[1] = CH_QMARK;
          e.seq[2] = ALT_DIGIT + c;
        end
        else
          e.seq[0] = CH_ZERO + c;
      end
      else
        case (id)
          KP_POINT:
          begin
            e.len    = al ? 2'd3 : 2'd1;
            e.seq[0] = al ? CH_ESC : 8'h2e;
            e.seq[1] = CH_QMARK;
            e.seq[2] = ALT_POINT;
          end
          // enter as return, enter in alternate mode
          KP_ENTER:
          begin
            e.len    = al ? 2'd3 : 2'd1;
            e.seq[0] = al ? CH_ESC : CH_CR;
            e.seq[1] = CH_QMARK;
            e.seq[2] = ALT_ENTER;
          end
          KP_UP:     e = esc2(EF_UP);
          KP_DOWN:   e = esc2(EF_DOWN);
          KP_RIGHT:  e = esc2(EF_RIGHT);
          KP_LEFT:   e = esc2(EF_LEFT);
          KP_TEST:   e = esc2(EF_TEST);
          KP_BACK:   e = esc2(EF_RASTER);
          KP_FWD:    e = esc2(EF_RESET);
          KP_BLANK0: e = esc2(EF_DOWN);
          KP_BLANK1: e = esc2(EF_RIGHT);
          KP_BLANK2: e = esc2(EF_LEFT);
          default:   e.len = 2'd0;
        endcase
    end
    else if (id == KEY_COPY)
      e.len = 2'd0;
    else
    begin
      if (c >= CH_LOW_A && c <= CH_LOW_Z)
      begin
        // control letters map onto the low codes
        if (ct)
          c = c & CTRL_MASK;
        // either shift or the lock gives uppercase
        else if (sh || lk)
          c = c - CASE_GAP;
      end
      // the lock never reaches digits or symbols
      else if (sh)
        c = shift_sym(c);
      e.seq[0] = c;
    end
    return e;
  endfunction : encode

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic       key_take;
  logic       code_take;
  logic       aw_take;
  logic       w_take;
  logic       ar_take;
  okg_enc_t   enc_new;
  okg_enc_t   enc_rpt;
  logic [7:0] c_in;

  assign key_ready     = (s.len == 2'd0);
  assign key_take      = key_valid && key_ready;
  assign code_valid    = (s.len != 2'd0);
  assign code_take     = code_valid && code_ready;
  assign c_in          = s.seq[0];
  assign s_axi_awready = !s.aw_held && !s.bvalid;
  assign s_axi_wready  = !s.w_held && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign ar_take       = s_axi_arvalid && s_axi_arready;
  assign enc_new       = encode(key_keypad, key_id, shift_key,
                                uppercase_lock_key, control_modifier_key,
                                s.alt);
  assign enc_rpt       = encode(s.last_kp, s.last_id, shift_key,
                                uppercase_lock_key, control_modifier_key,
                                s.alt);

  always_comb
  begin
    next_s           = s;
    next_s.act_valid = 1'b0;
    next_s.act       = ACT_NONE;

    // ----- Register bus -----
    if (aw_take)
    begin
      next_s.aw_held = 1'b1;
      next_s.awaddr  = s_axi_awaddr;
    end
    if (w_take)
    begin
      next_s.w_held = 1'b1;
      next_s.wdata  = s_axi_wdata;
      next_s.wstrb  = s_axi_wstrb;
    end
    if (s.aw_held && s.w_held)
    begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = addr_ok(s.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (s.awaddr == ADDR_CTRL && s.wstrb[0])
        next_s.alt = s.wdata[CTRL_ALT];
    end
    if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;
    if (ar_take)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      next_s.rdata  = '0;
      if (s_axi_araddr == ADDR_CTRL)
        next_s.rdata[CTRL_ALT] = s.alt;
      else if (s_axi_araddr == ADDR_STATUS)
      begin
        next_s.rdata[ST_ALT]   = s.alt;
        next_s.rdata[ST_MAINT] = s.maint;
        next_s.rdata[ST_BUSY]  = code_valid || (s.ip != IP_IDLE);
      end
    end
    else if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;

    // ----- Code stream, one byte leaves per handshake -----
    if (code_take)
    begin
      next_s.seq[0] = s.seq[1];
      next_s.seq[1] = s.seq[2];
      next_s.seq[2] = '0;
      next_s.len    = s.len - 2'd1;
    end

    // ----- Key intake and auto-repeat -----
    if (key_take)
    begin
      next_s.len      = enc_new.len;
      next_s.seq      = enc_new.seq;
      next_s.last_kp  = key_keypad;
      next_s.last_id  = key_id;
      next_s.last_rep = (enc_new.len != 2'd0);
      next_s.rpt      = '0;
      // copy only with a printer attached
      if (!key_keypad && key_id == KEY_COPY && printer_present)
      begin
        next_s.act_valid = 1'b1;
        next_s.act       = ACT_PRINT;
      end
    end
    else if (repeat_key && key_held && s.last_rep)
    begin
      if (s.len == 2'd0)
      begin
        if (s.rpt == RPT_LAST)
        begin
          next_s.rpt = '0;
          next_s.len = enc_rpt.len;
          next_s.seq = enc_rpt.seq;
        end
        else
          next_s.rpt = s.rpt + 24'h1;
      end
    end
    else
      next_s.rpt = '0;

    // ----- Local interpreter, fed from the code stream -----
    if (code_take)
      case (s.ip)
        IP_IDLE:
          if (c_in == CH_ESC)
            next_s.ip = IP_ESC;
          else if (c_in < CH_SP)
          begin
            next_s.act_valid = 1'b1;
            case (c_in)
              CH_BEL:  next_s.act = ACT_BELL;
              CH_BS:   next_s.act = ACT_BS;
              CH_TAB:  next_s.act = ACT_TAB;
              CH_LF:   next_s.act = ACT_LF;
              CH_CR:   next_s.act = ACT_CR;
              default: next_s.act_valid = 1'b0;
            endcase
          end
          else
          begin
            next_s.act_valid = 1'b1;
            next_s.act       = ACT_WRITE;
            next_s.act_char  = c_in;
          end
        IP_ESC:
        begin
          next_s.ip        = IP_IDLE;
          next_s.act_valid = 1'b1;
          case (c_in)
            EF_ALT_ON:
            begin
              next_s.alt       = 1'b1;
              next_s.act_valid = 1'b0;
            end
            EF_ALT_OFF:
            begin
              next_s.alt       = 1'b0;
              next_s.act_valid = 1'b0;
            end
            CH_QMARK:
            begin
              next_s.ip        = IP_ESCQ;
              next_s.act_valid = 1'b0;
            end
            EF_UP:     next_s.act = ACT_UP;
            EF_DOWN:   next_s.act = ACT_DOWN;
            EF_RIGHT:  next_s.act = ACT_RIGHT;
            EF_LEFT:   next_s.act = ACT_LEFT;
            EF_HOME:   next_s.act = ACT_HOME;
            EF_RLF:    next_s.act = ACT_RLF;
            EF_SCREEN_TAIL: next_s.act = ACT_SCREEN_TAIL;
            EF_LINE_TAIL:   next_s.act = ACT_LINE_TAIL;
            EF_TEST:   next_s.act = ACT_SELFTEST;
            EF_RASTER: next_s.act = ACT_RASTER;
            EF_RESET:  next_s.act = ACT_RESET;
            EF_PRINT:
            begin
              next_s.act       = ACT_PRINT;
              next_s.act_valid = printer_present;
            end
            EF_MAINT:
            begin
              next_s.maint     = 1'b1;
              next_s.act_valid = 1'b0;
            end
            // escape then E (45 hex) leaves maintenance
            EF_MAINT_X:
            begin
              next_s.maint     = 1'b0;
              next_s.act_valid = 1'b0;
            end
            default:   next_s.act_valid = 1'b0;
          endcase
        end
        // Alternate keypad sequences mean nothing locally
        IP_ESCQ: next_s.ip = IP_IDLE;
        default: next_s.ip = IP_IDLE;
      endcase

    if (!next_s.act_valid)
      next_s.act = ACT_NONE;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s       <= '0;
      s.ip    <= IP_IDLE;
      s.act   <= ACT_NONE;
      s.bresp <= RESP_OKAY;
      s.rresp <= RESP_OKAY;
    end
    else
      s <= next_s;
  end

  assign code          = s.seq[0];
  assign act_valid     = s.act_valid;
  assign act           = s.act;
  assign act_char      = s.act_char;
  assign alt_keypad    = s.alt;
  assign maint_mode    = s.maint;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic main_letter;
  assign main_letter = !key_keypad && key_id >= 7'h61 && key_id <= 7'h7a;

  ctrl_g_bell_a: assert property (
    key_take && main_letter && control_modifier_key && key_id == 7'h67
    |=> code_valid && code == 8'h07)
    else $error("control G did not give the bell code");
  bell_act_a: assert property (
    code_take && s.ip == IP_IDLE && code == 8'h07
    |=> act_valid && act == ACT_BELL)
    else $error("bell code did not ring the bell");
  upper_letter_a: assert property (
    key_take && main_letter && !control_modifier_key
    && (shift_key || uppercase_lock_key)
    |=> code == 8'({1'b0, $past(key_id)} - 8'h20))
    else $error("letter not uppercased");
  lock_digit_a: assert property (
    key_take && !key_keypad && key_id >= 7'h30 && key_id <= 7'h39
    && uppercase_lock_key && !shift_key
    |=> code == {1'b0, $past(key_id)})
    else $error("lock changed a digit");
  kp_plain_a: assert property (
    key_take && key_keypad && key_id <= 7'h09 && !s.alt
    |=> s.len == 2'd1 && code == 8'(8'h30 + {1'b0, $past(key_id)}))
    else $error("keypad digit wrong in normal mode");
  kp_alt_a: assert property (
    key_take && key_keypad && key_id <= 7'h09 && s.alt
    |=> s.len == 2'd3 && code == 8'h1b && s.seq[1] == 8'h3f
        && s.seq[2] == 8'(8'h70 + {1'b0, $past(key_id)}))
    else $error("alternate keypad sequence wrong");
  alt_set_a: assert property (
    code_take && s.ip == IP_ESC && code == 8'h3d |=> alt_keypad)
    else $error("alternate mode not set");
  screen_tail_a: assert property (
    code_take && s.ip == IP_ESC && code == 8'h4a
    |=> act_valid && act == ACT_SCREEN_TAIL && s.ip == IP_IDLE)
    else $error("erase to end of screen missing");
  unimpl_esc_a: assert property (
    code_take && s.ip == IP_ESC && code == 8'h40
    |=> !act_valid && s.ip == IP_IDLE && $stable(alt_keypad)
        && $stable(maint_mode))
    else $error("unimplemented escape had an effect");
  copy_print_a: assert property (
    key_take && !key_keypad && key_id == 7'h00
    |=> act_valid == $past(printer_present) && s.len == 2'd0)
    else $error("copy key mishandled");
  maint_exit_a: assert property (
    code_take && s.ip == IP_ESC && code == 8'h45 |=> !maint_mode)
    else $error("maintenance mode not left");
  repeat_fire_a: assert property (
    repeat_key && key_held && s.last_rep && !key_valid
    && s.len == 2'd0 && s.rpt == RPT_LAST
    |=> code_valid && s.rpt == 24'h0)
    else $error("repeat did not re-issue");
  write_resp_a: assert property (
    s.aw_held && s.w_held |=> s_axi_bvalid)
    else $error("write response late");

endmodule : okg_top
`default_nettype wire

/* File: tb/okg_display_model.sv */
`timescale 1ns/1ps
`default_nettype none
module okg_display_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       code_valid,
  input  wire logic [7:0] code,
  input  wire logic       stall,
  output logic            code_ready
);
  logic [7:0] got[$];
  logic       ph;
  // Slow mode takes a byte only every other cycle
  assign code_ready = !stall || ph;
  always @(posedge aclk)
  begin
    ph <= aresetn && !ph;
    if (aresetn && code_valid && code_ready)
      got.push_back(code);
  end
endmodule : okg_display_model
`default_nettype wire

/* File: tb/offline_keyboard_code_generator_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module offline_keyboard_code_generator_bench import okg_pkg::*;;
  logic aclk = 0, aresetn = 0, stall = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, q;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, key_ready, code_valid;
  logic key_valid = 0, key_keypad = 0, key_held = 0, shift_key = 0;
  logic uppercase_lock_key = 0, control_modifier_key = 0, repeat_key = 0;
  logic printer_present = 0, code_ready, act_valid, alt_keypad, maint_mode;
  logic [6:0] key_id = 0;
  logic [7:0] code, act_char;
  okg_act_t act, last_act = ACT_NONE;
  int fail_count = 0, samples_checked = 0;
  okg_top #(.REPEAT_LEN(8)) i_okg_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .key_valid(key_valid),
    .key_ready(key_ready), .key_keypad(key_keypad), .key_id(key_id),
    .key_held(key_held), .shift_key(shift_key),
    .uppercase_lock_key(uppercase_lock_key),
    .control_modifier_key(control_modifier_key),
    .repeat_key(repeat_key), .printer_present(printer_present),
    .code_valid(code_valid), .code(code), .code_ready(code_ready),
    .act_valid(act_valid), .act(act), .act_char(act_char),
    .alt_keypad(alt_keypad), .maint_mode(maint_mode)
  );
  okg_display_model i_okg_display_model (
    .aclk(aclk), .aresetn(aresetn), .code_valid(code_valid),
    .code(code), .stall(stall), .code_ready(code_ready)
  );
  initial forever #4 aclk = ~aclk;
  always @(posedge aclk) if (act_valid) last_act <= act;
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x)
    begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic axi(input logic w, input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, tr, dn;
    dn = 0;
    if (w)
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
    end
    else
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
    end
    while (!dn)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      dn = (s_axi_bready && s_axi_bvalid) || (s_axi_rready && s_axi_rvalid);
      rs = w ? s_axi_bresp : s_axi_rresp;
      q = s_axi_rdata;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tr) s_axi_arvalid <= 0;
      if (dn) s_axi_bready <= 0;
      if (dn) s_axi_rready <= 0;
    end
    // One idle edge so a following call never rewrites a ready twice
    @(posedge aclk);
  endtask : axi
  task automatic key(input logic kp, input logic [6:0] id, input int n,
                     input logic [23:0] e);
    logic t;
    int c;
    i_okg_display_model.got.delete();
    key_keypad <= kp;
    key_id <= id;
    key_valid <= 1;
    do
    begin
      @(negedge aclk);
      t = key_ready;
      @(posedge aclk);
    end while (!t);
    key_valid <= 0;
    c = 0;
    while (i_okg_display_model.got.size() < n && c < 60)
    begin
      @(posedge aclk);
      c++;
    end
    repeat (3) @(posedge aclk);
    chk(32'(i_okg_display_model.got.size()), 32'(n));
    for (int i = 0; i < n; i++)
      chk(i_okg_display_model.got[i], e[8*(n-1-i)+:8]);
  endtask : key
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    summarize();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    axi(0, 4'h0, 0);
    chk(q, 0);
    axi(0, 4'h8, 0);
    chk(rs, RESP_SLVERR);
    axi(1, 4'h8, 1);
    chk(rs, RESP_SLVERR);
    key(0, 7'h61, 1, 24'h61);
    shift_key <= 1;
    key(0, 7'h61, 1, 24'h41);
    shift_key <= 0;
    uppercase_lock_key <= 1;
    key(0, 7'h61, 1, 24'h41);
    key(0, 7'h31, 1, 24'h31);
    uppercase_lock_key <= 0;
    control_modifier_key <= 1;
    key(0, 7'h67, 1, 24'h07);
    chk(last_act, ACT_BELL);
    key(0, 7'h6d, 1, 24'h0d);
    chk(last_act, ACT_CR);
    key(0, 7'h68, 1, 24'h08);
    chk(last_act, ACT_BS);
    key(0, 7'h6b, 1, 24'h0b);
    chk(last_act, ACT_BS);
    control_modifier_key <= 0;
    key(0, 7'h20, 1, 24'h20);
    chk(act_char, 8'h20);
    shift_key <= 1;
    uppercase_lock_key <= 1;
    control_modifier_key <= 1;
    key(1, 7'h05, 1, 24'h35);
    key(1, KP_ENTER, 1, 24'h0d);
    key(1, KP_POINT, 1, 24'h2e);
    key(1, KP_TEST, 2, 24'h1b50);
    chk(last_act, ACT_SELFTEST);
    key(1, KP_UP, 2, 24'h1b41);
    key(1, KP_FWD, 2, 24'h1b52);
    chk(last_act, ACT_RESET);
    key(1, KP_BLANK0, 2, 24'h1b42);
    shift_key <= 0;
    uppercase_lock_key <= 0;
    control_modifier_key <= 0;
    stall <= 1;
    key(0, 7'h1b, 1, 24'h1b);
    key(0, 7'h3d, 1, 24'h3d);
    chk(alt_keypad, 1);
    key(1, 7'h00, 3, 24'h1b3f70);
    key(1, KP_NINE, 3, 24'h1b3f79);
    key(1, KP_ENTER, 3, 24'h1b3f4d);
    axi(0, 4'h4, 0);
    chk(q, 1);
    shift_key <= 1;
    key(0, 7'h1b, 1, 24'h1b);
    key(0, 7'h2e, 1, 24'h3e);
    chk(alt_keypad, 0);
    for (logic [6:0] i = 0; i < 4; i++)
    begin
      key(0, 7'h1b, 1, 24'h1b);
      key(0, 7'h68 + i, 1, 24'h48 + i);
      chk(last_act, ACT_HOME + i);
    end
    key(0, 7'h1b, 1, 24'h1b);
    key(0, 7'h6d, 1, 24'h4d);
    chk(maint_mode, 1);
    key(0, 7'h1b, 1, 24'h1b);
    key(0, 7'h65, 1, 24'h45);
    chk(maint_mode, 0);
    key(0, 7'h1b, 1, 24'h1b);
    key(0, 7'h32, 1, 24'h40);
    chk(last_act, ACT_LINE_TAIL);
    shift_key <= 0;
    printer_present <= 1;
    key(0, KEY_COPY, 0, 0);
    chk(last_act, ACT_PRINT);
    axi(1, 4'h0, 1);
    chk(rs, RESP_OKAY);
    axi(0, 4'h4, 0);
    chk(q, 1);
    axi(1, 4'h0, 0);
    repeat_key <= 1;
    key_held <= 1;
    key(0, 7'h78, 1, 24'h78);
    repeat (40) @(posedge aclk);
    chk(i_okg_display_model.got.size() > 2, 1);
    chk(i_okg_display_model.got[2], 8'h78);
    summarize();
  end
endmodule : offline_keyboard_code_generator_bench
`default_nettype wire
